/* design/spms_port.v */
// byte-wide serial peripheral port, master or slave, with apb registers
//
// Notes on behaviour
// - phase zero: slave drives first bit early
// - phase one: first clock edge starts transfer
// - phase one: select may stay low
// - queued byte follows at once, no gap
// - transmit empty tracks the holding buffer
// - slave resends last received byte if idle
// - master conflict: flag, request, drop enable
// - fault cleared by status read, control write
// - slave select rising flags a fault
// - slave byte ends on eighth returning edge
// - deselected slave floats output, clears count
// - select disabled: phase-one slave always selected
// - overrun keeps unread byte
// - complete flag requests unless empty enabled
// - empty flag requests when enabled; fault request
// - enable bit clear resets port logic
// - select disable bit ignores select pin, except in a phase-zero slave
// - polarity bit sets clock idle level
// - phase bit sets sampling edge
// - rate bits divide pclk by 4 to 128
// - master bit selects master or slave
// - master write loads idle shifter, starts
//
// The APB register port was decided locally.
`include "spms_regs.vh"

module spms_port #(
	parameter ADDR_W = 12
) (
	input  wire              pclk,
	input  wire              presetn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	output wire [31:0]       prdata,
	output wire              pready,
	output wire              pslverr,
	input  wire              sck_i,
	output wire              sck_o,
	output wire              sck_oe,
	input  wire              mosi_i,
	output wire              mosi_o,
	output wire              mosi_oe,
	input  wire              miso_i,
	output wire              miso_o,
	output wire              miso_oe,
	input  wire              ss_n_i,
	output wire              xfer_irq,
	output wire              select_conflict_flag_irq
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_MRUN = 2'h1;
	localparam [1:0] ST_SRUN = 2'h2;

	reg  [7:0]  ctrl_q;
	reg         lsbf_q;
	reg         teie_q;
	reg         modfie_q;
	reg         tc_q;
	reg         ovr_q;
	reg         select_conflict_flag_q;
	reg         tc_arm_q;
	reg         select_conflict_flag_arm_q;
	reg  [7:0]  txbuf_q;
	reg         txfull_q;
	reg  [7:0]  rdata_q;
	reg  [7:0]  tx_q;
	reg  [7:0]  rx_q;
	reg         out_q;
	reg         sck_q;
	reg  [1:0]  st_q;
	reg  [3:0]  edge_q;
	reg  [6:0]  div_q;
	reg         sck_d_q;
	reg         ss_d_q;
	reg  [31:0] prdata_q;
	reg         pslverr_q;

	wire [3:0]  pins_s;
	wire        sck_s  = pins_s[0];
	wire        mosi_s = pins_s[1];
	wire        miso_s = pins_s[2];
	wire        ss_s   = pins_s[3];

	// select resets high so an idle-high pin is not seen as a rise that flags a slave fault
	spms_sync #(
		.WIDTH   (4),
		.RST_VAL (4'h8)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_i ({ss_n_i, miso_i, mosi_i, sck_i}),
		.sync_o  (pins_s)
	);

	function [1:0] reg_sel;
		input [ADDR_W-1:0] addr;
		begin
			if (addr[1:0] != 2'h0)
				reg_sel = `SPMS_SEL_NONE;
			else if (addr[ADDR_W-1:2] == `SPMS_IDX_CTRL)
				reg_sel = `SPMS_SEL_CTRL;
			else if (addr[ADDR_W-1:2] == `SPMS_IDX_STAT)
				reg_sel = `SPMS_SEL_STAT;
			else if (addr[ADDR_W-1:2] == `SPMS_IDX_DATA)
				reg_sel = `SPMS_SEL_DATA;
			else
				reg_sel = `SPMS_SEL_NONE;
		end
	endfunction

	function first_bit;
		input [7:0] b;
		input       lsbf;
		begin
			first_bit = lsbf ? b[0] : b[7];
		end
	endfunction

	function [7:0] shift_out;
		input [7:0] b;
		input       lsbf;
		begin
			shift_out = lsbf ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
		end
	endfunction

	function [7:0] shift_in;
		input [7:0] b;
		input       bit_in;
		input       lsbf;
		begin
			shift_in = lsbf ? {bit_in, b[7:1]} : {b[6:0], bit_in};
		end
	endfunction

	// control fields
	// enable bit
	wire       en    = ctrl_q[`SPMS_C_EN];
	wire       master_select_bit  = ctrl_q[`SPMS_C_MASTER_SELECT_BIT];
	wire       clock_idle_level  = ctrl_q[`SPMS_C_CLOCK_IDLE_LEVEL];
	wire       clock_sample_edge  = ctrl_q[`SPMS_C_CLOCK_SAMPLE_EDGE];
	wire       select_pin_disable = ctrl_q[`SPMS_C_SELECT_PIN_DISABLE];
	wire [2:0] rate  = {ctrl_q[`SPMS_C_RATE2], ctrl_q[`SPMS_C_RATE1],
		ctrl_q[`SPMS_C_RATE0]};

	// invalid rate codes never start a master transfer
	wire       rate_ok = (rate >= `SPMS_RATE_MIN) && (rate <= `SPMS_RATE_MAX);
	wire [6:0] half_m1 = (`SPMS_HALF_ONE << rate) - `SPMS_HALF_ONE;

	// disable bit is void for a phase-zero slave
	wire ss_used  = !select_pin_disable | (!master_select_bit & !clock_sample_edge);
	wire selected = !master_select_bit & (ss_used ? !ss_s : 1'b1);
	wire ss_fall  = ss_used & ss_d_q & !ss_s;
	wire ss_rise  = ss_used & !ss_d_q & ss_s;

	// low select on a master is a conflict
	wire m_fault = en & master_select_bit & !select_pin_disable & !ss_s;
	// slave select rising after being low
	wire s_fault = en & !master_select_bit & ss_rise;

	// edges are judged against the idle level
	wire s_lead_raw  = (sck_s != clock_idle_level) && (sck_d_q == clock_idle_level);
	wire s_trail_raw = (sck_s == clock_idle_level) && (sck_d_q != clock_idle_level);

	wire m_tick  = (st_q == ST_MRUN) && (div_q == 7'h00);
	wire m_lead  = m_tick && (sck_q == clock_idle_level);
	wire m_trail = m_tick && (sck_q != clock_idle_level);
	wire s_lead  = (st_q == ST_SRUN) && selected && s_lead_raw;
	wire s_trail = (st_q == ST_SRUN) && selected && s_trail_raw;

	wire ev_lead  = m_lead | s_lead;
	wire ev_trail = m_trail | s_trail;
	wire in_bit   = master_select_bit ? miso_s : mosi_s;
	wire last     = (edge_q == `SPMS_LAST_EDGE);
	// byte ends on the sixteenth edge, back at idle
	wire done     = ev_trail && last;

	// phase zero samples leading edges, phase one trailing
	wire sample = (ev_lead & !clock_sample_edge) | (ev_trail & clock_sample_edge);
	wire [7:0] rx_fin = (ev_trail & clock_sample_edge) ? shift_in(rx_q, in_bit, lsbf_q)
		: rx_q;

	// master start from idle as soon as a byte waits
	wire m_start = en && master_select_bit && (st_q == ST_IDLE) && txfull_q && rate_ok
		&& !m_fault;
	// master chains a queued byte on the closing edge
	wire m_load  = m_start | (master_select_bit & done & txfull_q);
	// phase zero slave loads on the select fall
	// phase one slave loads on the first edge
	wire s_load  = en && !master_select_bit && (((st_q == ST_IDLE) && selected && !clock_sample_edge
		&& ss_fall) || (s_lead && clock_sample_edge && (edge_q == `SPMS_EDGE_ZERO)));
	// nothing queued, the last received byte goes out
	wire [7:0] ld_byte = txfull_q ? txbuf_q : rx_q;
	// a phase-one master puts its first bit out on the first edge
	wire ld_drive = s_load | (m_load & !clock_sample_edge);
	wire drive    = (ev_lead & clock_sample_edge & !s_load) | (ev_trail & !clock_sample_edge & !last);

	wire       acc   = psel & penable;
	wire       wr    = acc & pwrite;
	wire       rd    = acc & !pwrite;
	wire [1:0] sel_a = reg_sel(paddr);
	wire [7:0] stat_v;

	// empty flag is the inverse of the holding buffer
	assign stat_v = {tc_q, 1'b0, ovr_q, select_conflict_flag_q, !txfull_q, lsbf_q, teie_q,
		modfie_q};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q     <= `SPMS_CTRL_RST;
			lsbf_q     <= 1'b0;
			teie_q     <= 1'b0;
			modfie_q   <= 1'b0;
			tc_q       <= 1'b0;
			ovr_q      <= 1'b0;
			select_conflict_flag_q     <= 1'b0;
			tc_arm_q   <= 1'b0;
			select_conflict_flag_arm_q <= 1'b0;
			txbuf_q    <= 8'h00;
			txfull_q   <= 1'b0;
			rdata_q    <= 8'h00;
			tx_q       <= 8'h00;
			rx_q       <= 8'h00;
			out_q      <= 1'b0;
			sck_q      <= 1'b0;
			st_q       <= ST_IDLE;
			edge_q     <= `SPMS_EDGE_ZERO;
			div_q      <= 7'h00;
			sck_d_q    <= 1'b0;
			ss_d_q     <= 1'b1;
		end else begin
			sck_d_q <= sck_s;
			ss_d_q  <= ss_s;

			// bus side; clears come first so hardware sets win below
			if (wr && (sel_a == `SPMS_SEL_CTRL)) begin
				// enable stays off while a fault is pending
				ctrl_q <= select_conflict_flag_q ? (pwdata[7:0] & `SPMS_EN_CLR)
					: pwdata[7:0];
				if (select_conflict_flag_arm_q) begin
					select_conflict_flag_q     <= 1'b0;
					select_conflict_flag_arm_q <= 1'b0;
				end
			end
			if (wr && (sel_a == `SPMS_SEL_STAT)) begin
				lsbf_q   <= pwdata[`SPMS_S_LSBF];
				teie_q   <= pwdata[`SPMS_S_TEIE];
				modfie_q <= pwdata[`SPMS_S_MODFIE];
			end
			if (rd && (sel_a == `SPMS_SEL_STAT)) begin
				tc_arm_q   <= tc_q;
				select_conflict_flag_arm_q <= select_conflict_flag_q;
				ovr_q      <= 1'b0;
			end
			if (acc && (sel_a == `SPMS_SEL_DATA) && tc_arm_q) begin
				tc_q     <= 1'b0;
				tc_arm_q <= 1'b0;
			end
			// a write while the buffer is full is dropped
			if (wr && (sel_a == `SPMS_SEL_DATA) && en && !txfull_q) begin
				txbuf_q  <= pwdata[7:0];
				txfull_q <= 1'b1;
			end

			// shift engine
			if (ev_lead | ev_trail)
				edge_q <= edge_q + `SPMS_EDGE_ONE;
			if (sample)
				rx_q <= shift_in(rx_q, in_bit, lsbf_q);
			if (drive) begin
				out_q <= first_bit(tx_q, lsbf_q);
				tx_q  <= shift_out(tx_q, lsbf_q);
			end
			if (m_load | s_load) begin
				if (txfull_q)
					txfull_q <= 1'b0;
				if (ld_drive) begin
					out_q <= first_bit(ld_byte, lsbf_q);
					tx_q  <= shift_out(ld_byte, lsbf_q);
				end else begin
					tx_q <= ld_byte;
				end
			end
			if (done) begin
				// unread byte is kept, overrun flagged
				if (tc_q) begin
					ovr_q <= 1'b1;
				end else begin
					rdata_q <= rx_fin;
					tc_q    <= 1'b1;
				end
			end

			case (st_q)
				ST_IDLE: begin
					sck_q  <= clock_idle_level;
					edge_q <= `SPMS_EDGE_ZERO;
					div_q  <= half_m1;
					if (m_start)
						st_q <= ST_MRUN;
					else if (en && !master_select_bit && selected)
						st_q <= ST_SRUN;
				end
				ST_MRUN: begin
					if (!master_select_bit) begin
						st_q <= ST_IDLE;
					end else if (m_tick) begin
						div_q <= half_m1;
						sck_q <= !sck_q;
						if (done && !txfull_q)
							st_q <= ST_IDLE;
					end else begin
						div_q <= div_q - 7'h01;
					end
				end
				ST_SRUN: begin
					if (master_select_bit || !selected) begin
						st_q   <= ST_IDLE;
						edge_q <= `SPMS_EDGE_ZERO;
					end
				end
				default: st_q <= ST_IDLE;
			endcase

			// master conflict drops enable and master bits
			if (m_fault) begin
				select_conflict_flag_q            <= 1'b1;
				ctrl_q[`SPMS_C_EN]   <= 1'b0;
				ctrl_q[`SPMS_C_MASTER_SELECT_BIT] <= 1'b0;
				st_q              <= ST_IDLE;
			end
			if (s_fault)
				select_conflict_flag_q <= 1'b1;

			// disabled port returns to its idle state
			if (!en) begin
				st_q     <= ST_IDLE;
				edge_q   <= `SPMS_EDGE_ZERO;
				txfull_q <= 1'b0;
				sck_q    <= clock_idle_level;
			end
		end
	end

	// read data is captured in the setup phase so no wait state is needed
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_q <= (sel_a == `SPMS_SEL_NONE);
			case (sel_a)
				`SPMS_SEL_CTRL: prdata_q <= {24'h000000, ctrl_q};
				`SPMS_SEL_STAT: prdata_q <= {24'h000000, stat_v};
				`SPMS_SEL_DATA: prdata_q <= {24'h000000, rdata_q};
				default:        prdata_q <= 32'h00000000;
			endcase
		end
	end

	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;
	assign pready  = 1'b1;

	assign sck_o   = sck_q;
	assign sck_oe  = en & master_select_bit;
	assign mosi_o  = out_q;
	assign mosi_oe = en & master_select_bit;
	assign miso_o  = out_q;
	assign miso_oe = en & !master_select_bit & selected;

	// complete flag only while empty requests are off
	assign xfer_irq = en & (teie_q ? !txfull_q : tc_q);
	// no fault request with the select pin disabled
	assign select_conflict_flag_irq = select_conflict_flag_q & modfie_q & !select_pin_disable;

endmodule

/* design/spms_regs.vh */
// register map, field positions and reset values of the serial port
`ifndef SPMS_REGS_VH
`define SPMS_REGS_VH

// register indexes; byte address is four times the index
`define SPMS_IDX_CTRL   10'h0D4
`define SPMS_IDX_STAT   10'h0D5
`define SPMS_IDX_DATA   10'h0D6

// register select codes used by the address decoder
`define SPMS_SEL_NONE   2'h0
`define SPMS_SEL_CTRL   2'h1
`define SPMS_SEL_STAT   2'h2
`define SPMS_SEL_DATA   2'h3

// serial_port_control fields and reset value
`define SPMS_CTRL_RST   8'h14
`define SPMS_C_RATE2    7
`define SPMS_C_EN       6
`define SPMS_C_SELECT_PIN_DISABLE    5
`define SPMS_C_MASTER_SELECT_BIT     4
`define SPMS_C_CLOCK_IDLE_LEVEL     3
`define SPMS_C_CLOCK_SAMPLE_EDGE     2
`define SPMS_C_RATE1    1
`define SPMS_C_RATE0    0
`define SPMS_EN_CLR     8'hBF

// serial_port_status_control fields
`define SPMS_S_TC       7
`define SPMS_S_OVR      5
`define SPMS_S_SELECT_CONFLICT_FLAG     4
`define SPMS_S_TE       3
`define SPMS_S_LSBF     2
`define SPMS_S_TEIE     1
`define SPMS_S_MODFIE   0

// divider: code n gives a half period of 2**n pclk cycles
`define SPMS_RATE_MIN   3'h1
`define SPMS_RATE_MAX   3'h6
`define SPMS_HALF_ONE   7'h01

// sixteen serial clock edges per byte
`define SPMS_LAST_EDGE  4'hF
`define SPMS_EDGE_ONE   4'h1
`define SPMS_EDGE_ZERO  4'h0

`endif

/* design/spms_sync.v */
// two-stage synchroniser for a group of asynchronous pin inputs
module spms_sync #(
	parameter       WIDTH   = 4,
	parameter [3:0] RST_VAL = 4'h0
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= RST_VAL[WIDTH-1:0];
			sync_q <= RST_VAL[WIDTH-1:0];
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

/* tb/spms_chk.sv */
// assertions on the serial port's apb answer and pin enables
module spms_chk #(
	parameter ADDR_W = 12
) (
	input logic              pclk,
	input logic              presetn,
	input logic              psel,
	input logic              penable,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0]       prdata,
	input logic              pready,
	input logic              pslverr,
	input logic              sck_o,
	input logic              sck_oe,
	input logic              mosi_oe,
	input logic              miso_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_apb_ready:
		assert property (pready) else $error("pready low");
	chk_bad_addr:
		assert property (psel && penable &&
			!(paddr inside {12'h350, 12'h354, 12'h358}) |-> pslverr)
		else $error("no error on unmapped address");
	chk_good_addr:
		assert property (psel && penable &&
			(paddr inside {12'h350, 12'h354, 12'h358}) |-> !pslverr)
		else $error("error on mapped address");
	chk_byte_wide:
		assert property (prdata[31:8] == 24'h0) else $error("upper bits set");
	chk_master_pins:
		assert property (sck_oe == mosi_oe) else $error("master enables split");
	chk_one_driver:
		assert property (!(miso_oe && sck_oe)) else $error("both ends drive");
	chk_sck_rate:
		assert property ($changed(sck_o) && sck_oe ##1 sck_oe |-> $stable(sck_o))
		else $error("clock half period too short");
	chk_reset_quiet:
		assert property ($rose(presetn) |-> !sck_oe && !miso_oe)
		else $error("pins driven after reset");
endmodule

bind spms_port spms_chk #(.ADDR_W(ADDR_W)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe)
);

/* tb/spms_slave_model.sv */
// behavioural far-side slave: phase one, clock idle low
module spms_slave_model (
	input  logic       sck,
	input  logic       mosi,
	input  logic       sel_n,
	input  logic [7:0] seed,
	output logic       miso,
	output logic [7:0] rx_last,
	output int         n_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] tx_q;
	logic [7:0] sh_q;
	logic       sck_q = 1'b0;
	logic       sel_q = 1'b1;
	int         cnt_q;
	int         rx_n  = 0;
	assign n_rx = rx_n;
	// one process owns every output so nothing has two drivers
	always @(sck or sel_n) begin
		if (sel_n) begin
			// released line never keeps its level
			if (!sel_q)
				miso <= ~miso;
		end else if (sel_q) begin
			tx_q = seed;
			cnt_q = 0;
		end else if (sck && !sck_q) begin
			miso <= tx_q[7];
			tx_q = {tx_q[6:0], 1'b0};
		end else if (!sck && sck_q) begin
			// sample on trailing edge, select held
			sh_q = {sh_q[6:0], mosi};
			cnt_q++;
			if (cnt_q == 8) begin
				cnt_q = 0;
				rx_last <= sh_q;
				rx_n <= rx_n + 1;
				tx_q = ~sh_q;
			end
		end
		sck_q = sck;
		sel_q = sel_n;
	end
endmodule

/* tb/testbench.sv */
// self-checking bench: registers, master link, faults
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] CTRL = 12'h350;
	localparam logic [11:0] STAT = 12'h354;
	localparam logic [11:0] DATA = 12'h358;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        ss_n = 1'b1;
	logic        sel_n = 1'b1;
	logic        lnk_sck = 1'b0;
	logic        lnk_mosi = 1'b0;
	logic        lnk_miso;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, sck_o, sck_oe, mosi_o, mosi_oe;
	logic        miso, miso_oe, xfer_irq, select_conflict_flag_irq;
	logic [7:0]  rx_last;
	int          n_rx, fail_count = 0, num_checks = 0;

	always #25 pclk = ~pclk;

	spms_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sck_i(lnk_sck), .sck_o(sck_o), .sck_oe(sck_oe),
		.mosi_i(lnk_mosi), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(miso), .miso_o(lnk_miso),
		.miso_oe(miso_oe),
		.ss_n_i(ss_n), .xfer_irq(xfer_irq), .select_conflict_flag_irq(select_conflict_flag_irq));
	spms_slave_model peer (.sck(sck_o), .mosi(mosi_o), .sel_n(sel_n),
		.seed(8'h3C), .miso(miso), .rx_last(rx_last), .n_rx(n_rx));

	task automatic stop_test;
		if (fail_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic hang;
		fail_count++;
		stop_test;
	endtask
	task automatic check(input string nm, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 16) hang;
	endtask
	task automatic wait_rx(input int k);
		for (int n = 0; n < 3000 && n_rx < k; n++) @(posedge pclk);
		if (n_rx < k) hang;
		repeat (8) @(posedge pclk);
	endtask

	task automatic t_reset;
		apb(0, CTRL, 0);
		check("ctrl reset", rd, 32'h14);
		apb(0, STAT, 0);
		check("status reset", rd, 32'h08);
		apb(0, 12'h010, 0);
		check("unmapped", er, 1'b1);
	endtask
	task automatic t_queue;
		apb(1, CTRL, 8'h56);
		apb(1, DATA, 8'hA5);
		apb(1, DATA, 8'h5A);
		apb(0, STAT, 0);
		check("buffer full", rd, 32'h00);
		wait_rx(2);
		check("peer byte", rx_last, 8'h5A);
		check("tc irq", xfer_irq, 1'b1);
		apb(0, STAT, 0);
		check("overrun", rd, 32'hA8);
		apb(0, DATA, 0);
		check("kept byte", rd, 32'h3C);
		apb(0, STAT, 0);
		check("flags clear", rd, 32'h08);
		check("irq off", xfer_irq, 1'b0);
		apb(1, STAT, 8'h02);
		check("te irq", xfer_irq, 1'b1);
	endtask
	task automatic t_rate;
		logic s;
		int   n, k;
		for (int c = 1; c <= 6; c++) begin
			apb(1, CTRL, {c[2], 5'b10101, c[1:0]});
			k = n_rx;
			apb(1, DATA, 8'h00);
			s = sck_o;
			for (n = 0; n < 300 && sck_o === s; n++) @(posedge pclk);
			s = sck_o;
			for (n = 0; n < 300 && sck_o === s; n++) @(posedge pclk);
			check("half period", n, 32'h1 << c);
			wait_rx(k + 1);
			apb(0, STAT, 0);
			apb(0, DATA, 0);
		end
		apb(1, CTRL, 8'h54);
		apb(1, DATA, 8'h00);
		repeat (40) @(posedge pclk);
		check("idle clock", sck_o, 1'b0);
		apb(0, STAT, 0);
		check("no start", rd, 32'h02);
		apb(1, CTRL, 8'h16);
		apb(0, STAT, 0);
		check("disable clears", rd, 32'h0A);
		apb(1, CTRL, 8'hD6);
	endtask
	task automatic t_fault;
		apb(1, STAT, 8'h01);
		ss_n <= 1'b0;
		repeat (8) @(posedge pclk);
		check("select_conflict_flag irq", select_conflict_flag_irq, 1'b1);
		check("master off", sck_oe, 1'b0);
		apb(0, CTRL, 0);
		check("ctrl fault", rd, 32'h86);
		apb(1, CTRL, 8'h56);
		check("flag held", select_conflict_flag_irq, 1'b1);
		ss_n <= 1'b1;
		apb(0, STAT, 0);
		check("select_conflict_flag flag", rd, 32'h19);
		apb(1, CTRL, 8'h56);
		apb(0, CTRL, 0);
		check("en blocked", rd, 32'h16);
		apb(1, CTRL, 8'h56);
		apb(0, CTRL, 0);
		check("en again", rd, 32'h56);
		check("select_conflict_flag off", select_conflict_flag_irq, 1'b0);
	endtask
	task automatic t_slave;
		apb(1, CTRL, 8'h44);
		ss_n <= 1'b0;
		repeat (8) @(posedge pclk);
		check("slave drives", miso_oe, 1'b1);
		ss_n <= 1'b1;
		repeat (8) @(posedge pclk);
		check("slave floats", miso_oe, 1'b0);
		check("slave fault", select_conflict_flag_irq, 1'b1);
	endtask
	// far-side master, phase zero, clock idle low, 8 pclk half period
	task automatic lnk_byte(input logic [7:0] tx, output logic [7:0] rx);
		ss_n <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			lnk_mosi <= tx[i];
			repeat (8) @(posedge pclk);
			rx[i] = lnk_miso;
			lnk_sck <= 1'b1;
			repeat (8) @(posedge pclk);
			lnk_sck <= 1'b0;
		end
		repeat (8) @(posedge pclk);
		ss_n <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
	task automatic t_link;
		logic [7:0] r1, r2;
		apb(0, STAT, 0);
		apb(1, CTRL, 8'h40);
		apb(1, CTRL, 8'h40);
		apb(1, DATA, 8'hC3);
		lnk_byte(8'h96, r1);
		lnk_byte(8'h0F, r2);
		check("slave out", r1, 8'hC3);
		check("resend", r2, 8'h96);
		apb(0, STAT, 0);
		check("slave flags", rd, 32'hB9);
		apb(0, DATA, 0);
		check("slave kept", rd, 32'h96);
	endtask

	initial begin
		#4000000;
		hang;
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		sel_n <= 1'b0;
		@(posedge pclk);
		t_reset;
		t_queue;
		t_rate;
		t_fault;
		t_slave;
		t_link;
		stop_test;
	end
endmodule
